//--- hdl/xxe_exec.sv
// Exchange, digit exchange and exclusive-or execution unit with accumulator
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Byte swap moves operand to accumulator, accumulator back.
// - Byte swap operand: bank register, direct, or indirect.
// - Byte swap opcodes decoded; register and direct forms four cycles, indirect six.
// - Digit swap exchanges low nibbles with indirect byte.
// - Digit swap keeps both high nibbles unchanged.
// - Digit swap opcode 1101011i; six cycles; flags untouched.
// - Xor combines bitwise, writes destination, flags untouched.
// - Xor supports six source/destination combinations.
// - Xor into port reads output latch, not pins.
// - Xor to accumulator opcodes decoded; immediate one cycle, register and direct three, indirect five.
// - Opcode 01100010 xors accumulator into direct byte.
module xxe_exec (
	input  wire logic       CLK,
	input  wire logic       RST_N,
	input  wire logic       START,
	input  wire logic [7:0] OPCODE,
	input  wire logic [7:0] OPERAND1,
	input  wire logic [7:0] OPERAND2,
	input  wire logic [1:0] BANK,
	input  wire logic       ACC_WR_EN,
	input  wire logic [7:0] ACC_WR_DATA,
	input  wire logic [7:0] RD_DATA,
	output logic            BUSY,
	output logic            DONE,
	output logic            ILLEGAL,
	output logic            MEM_RD,
	output logic            MEM_WR,
	output logic            MEM_IND,
	output logic            MEM_LATCH,
	output logic [7:0]      MEM_ADDR,
	output logic [7:0]      MEM_WDATA,
	output logic [7:0]      ACC,
	output logic            PARITY
);
	xxe_pkg::xxe_state_e state_q, state_d;
	logic [7:0] acc_q, acc_d;
	logic [7:0] addr_q, addr_d;
	logic [7:0] op_q, imm_q, wdata_q, wdata_d;
	logic       ind_q, ind_d, done_q, done_d, ill_q, par_q;

	////////////////////////////////////////////////////////////////////////
	// Decode the live opcode while idle, the held one afterwards
	wire       idle     = (state_q == xxe_pkg::ST_IDLE);
	wire [7:0] cur_op   = idle ? OPCODE : op_q;
	wire c_swap_r  = (cur_op[7:3] == xxe_pkg::OP_SWAP_REG_PFX);
	wire c_swap_i  = (cur_op[7:1] == xxe_pkg::OP_SWAP_IND_PFX);
	wire c_swap_d  = (cur_op == xxe_pkg::OP_SWAP_DIR);
	wire c_digit   = (cur_op[7:1] == xxe_pkg::OP_DIGIT_PFX);
	wire c_xor_r   = (cur_op[7:3] == xxe_pkg::OP_XOR_REG_PFX);
	wire c_xor_i   = (cur_op[7:1] == xxe_pkg::OP_XOR_IND_PFX);
	wire c_xor_d   = (cur_op == xxe_pkg::OP_XOR_DIR);
	wire c_xor_imm = (cur_op == xxe_pkg::OP_XOR_IMM);
	wire c_xor_da  = (cur_op == xxe_pkg::OP_XOR_DIR_ACC);
	wire c_xor_di  = (cur_op == xxe_pkg::OP_XOR_DIR_IMM);
	wire c_swap    = c_swap_r | c_swap_i | c_swap_d;
	wire c_xor_acc = c_xor_r | c_xor_i | c_xor_d;
	wire c_xor_dst = c_xor_da | c_xor_di;
	wire c_indir   = c_swap_i | c_digit | c_xor_i;
	wire c_regfm   = c_swap_r | c_xor_r;
	wire c_known   = c_swap | c_digit | c_xor_acc | c_xor_imm | c_xor_dst;
	wire take      = idle & START & c_known;

	// Operand addresses: bank register, pointer register, or direct byte
	wire [7:0] reg_addr = {xxe_pkg::BANK_ADDR_TOP, BANK, OPCODE[2:0]};
	wire [7:0] ptr_addr = {xxe_pkg::BANK_ADDR_TOP, BANK,
	                       xxe_pkg::PTR_REG_HIGH, OPCODE[0]};
	wire [7:0] first_addr = c_indir ? ptr_addr :
	                        c_regfm ? reg_addr : OPERAND1;

	// Results formed from the operand byte returned this cycle
	wire [7:0] digit_acc = {acc_q[7:4], RD_DATA[3:0]};
	wire [7:0] digit_mem = {RD_DATA[7:4], acc_q[3:0]};
	wire [7:0] xor_acc   = acc_q ^ RD_DATA;
	wire [7:0] xor_dst   = RD_DATA ^ (c_xor_di ? imm_q : acc_q);
	wire       needs_wr  = c_swap | c_digit | c_xor_dst;

	////////////////////////////////////////////////////////////////////////
	// Sequencer and datapath next-state logic
	always_comb begin
		state_d = state_q;
		acc_d   = acc_q;
		addr_d  = addr_q;
		ind_d   = ind_q;
		wdata_d = wdata_q;
		done_d  = 1'b0;
		case (state_q)
			xxe_pkg::ST_IDLE: begin
				if (take && c_xor_imm) begin
					// No memory access, so the result lands at once
					acc_d  = acc_q ^ OPERAND1;
					done_d = 1'b1;
				end else if (take) begin
					addr_d  = first_addr;
					ind_d   = c_indir;
					state_d = c_indir ? xxe_pkg::ST_PTR : xxe_pkg::ST_OPRD;
				end else if (ACC_WR_EN) begin
					acc_d = ACC_WR_DATA;
				end
			end
			xxe_pkg::ST_PTR: begin
				state_d = xxe_pkg::ST_PTRW;
			end
			xxe_pkg::ST_PTRW: begin
				addr_d  = RD_DATA; // Pointer value becomes the address
				state_d = xxe_pkg::ST_OPRD;
			end
			xxe_pkg::ST_OPRD: begin
				state_d = xxe_pkg::ST_CALC;
			end
			xxe_pkg::ST_CALC: begin
				if (c_swap) begin
					acc_d   = RD_DATA;
					wdata_d = acc_q;
				end else if (c_digit) begin
					acc_d   = digit_acc;
					wdata_d = digit_mem;
				end else if (c_xor_dst) begin
					wdata_d = xor_dst;
				end else begin
					acc_d = xor_acc;
				end
				done_d  = ~needs_wr;
				state_d = needs_wr ? xxe_pkg::ST_WR : xxe_pkg::ST_IDLE;
			end
			xxe_pkg::ST_WR: begin
				done_d  = 1'b1;
				state_d = xxe_pkg::ST_IDLE;
			end
			default: begin
				state_d = xxe_pkg::ST_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// State registers; parity follows the accumulator's next value
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			state_q <= xxe_pkg::ST_IDLE;
			acc_q   <= xxe_pkg::ACC_RESET;
			par_q   <= 1'b0;
			addr_q  <= xxe_pkg::BYTE_ZERO;
			ind_q   <= 1'b0;
			wdata_q <= xxe_pkg::BYTE_ZERO;
			done_q  <= 1'b0;
			ill_q   <= 1'b0;
		end else begin
			state_q <= state_d;
			acc_q   <= acc_d;
			par_q   <= ^acc_d;
			addr_q  <= addr_d;
			ind_q   <= ind_d;
			wdata_q <= wdata_d;
			done_q  <= done_d;
			ill_q   <= idle & START & ~c_known;
		end
	end

	// Instruction bytes are held so the caller may change them once taken
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			op_q  <= xxe_pkg::BYTE_ZERO;
			imm_q <= xxe_pkg::BYTE_ZERO;
		end else if (take) begin
			op_q  <= OPCODE;
			imm_q <= OPERAND2;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs; the latch select keeps pin levels out of port updates
	assign BUSY      = ~idle;
	assign DONE      = done_q;
	assign ILLEGAL   = ill_q;
	assign MEM_RD    = (state_q == xxe_pkg::ST_PTR) |
	                   (state_q == xxe_pkg::ST_OPRD);
	assign MEM_WR    = (state_q == xxe_pkg::ST_WR);
	assign MEM_IND   = ind_q & (state_q != xxe_pkg::ST_PTR);
	assign MEM_LATCH = (state_q == xxe_pkg::ST_OPRD) & c_xor_dst;
	assign MEM_ADDR  = addr_q;
	assign MEM_WDATA = wdata_q;
	assign ACC       = acc_q;
	assign PARITY    = par_q;

	////////////////////////////////////////////////////////////////////////
	// Checks on the datapath and timing
	a_swap_acc_load: assert property (
		@(posedge CLK) disable iff (!RST_N)
		(state_q == xxe_pkg::ST_CALC && c_swap) |=> acc_q == $past(RD_DATA))
		else $error("swap did not load operand into accumulator");
	a_swap_writeback: assert property (
		@(posedge CLK) disable iff (!RST_N)
		(state_q == xxe_pkg::ST_CALC && c_swap)
		|=> MEM_WR && MEM_WDATA == $past(acc_q))
		else $error("swap did not write old accumulator back");
	a_swap_dir_time: assert property (
		@(posedge CLK) disable iff (!RST_N)
		(idle && START && OPCODE == xxe_pkg::OP_SWAP_DIR)
		|=> MEM_RD && MEM_ADDR == $past(OPERAND1) ##2 MEM_WR ##1 DONE)
		else $error("direct swap address or timing wrong");
	a_reg_select: assert property (
		@(posedge CLK) disable iff (!RST_N)
		(take && c_regfm) |=> MEM_RD && MEM_ADDR[4:0] == $past({BANK, OPCODE[2:0]}))
		else $error("bank register address wrong");
	a_ptr_select: assert property (
		@(posedge CLK) disable iff (!RST_N)
		(take && c_indir) |=> MEM_RD && !MEM_IND
		&& MEM_ADDR == $past(ptr_addr) ##2 MEM_RD && MEM_IND)
		else $error("pointer register fetch wrong");
	a_digit_low: assert property (
		@(posedge CLK) disable iff (!RST_N)
		(state_q == xxe_pkg::ST_CALC && c_digit)
		|=> acc_q[3:0] == $past(RD_DATA[3:0]) && MEM_WDATA[3:0] == $past(acc_q[3:0]))
		else $error("digit swap low nibbles wrong");
	a_digit_high: assert property (
		@(posedge CLK) disable iff (!RST_N)
		(state_q == xxe_pkg::ST_CALC && c_digit)
		|=> acc_q[7:4] == $past(acc_q[7:4]) && MEM_WDATA[7:4] == $past(RD_DATA[7:4]))
		else $error("digit swap disturbed high nibbles");
	a_digit_time: assert property (
		@(posedge CLK) disable iff (!RST_N)
		(idle && START && c_digit) |-> ##5 MEM_WR ##1 DONE)
		else $error("digit swap timing wrong");
	a_xor_acc: assert property (
		@(posedge CLK) disable iff (!RST_N)
		(state_q == xxe_pkg::ST_CALC && c_xor_acc)
		|=> acc_q == ($past(acc_q) ^ $past(RD_DATA)) && DONE && !MEM_WR)
		else $error("xor into accumulator wrong");
	a_xor_imm: assert property (
		@(posedge CLK) disable iff (!RST_N)
		(idle && START && OPCODE == xxe_pkg::OP_XOR_IMM)
		|=> acc_q == ($past(acc_q) ^ $past(OPERAND1)) && DONE)
		else $error("xor immediate into accumulator wrong");
	a_xor_reg_time: assert property (
		@(posedge CLK) disable iff (!RST_N)
		(idle && START && c_xor_r) |-> ##3 DONE)
		else $error("xor register form timing wrong");
	// Checked from the taking edge, so a wrong read state or address shows
	a_port_latch: assert property (
		@(posedge CLK) disable iff (!RST_N)
		(take && c_xor_dst) |=> MEM_RD && MEM_LATCH && !MEM_IND
		&& MEM_ADDR == $past(OPERAND1))
		else $error("port update not read from latch");
	a_xor_dir_acc: assert property (
		@(posedge CLK) disable iff (!RST_N)
		(idle && START && OPCODE == xxe_pkg::OP_XOR_DIR_ACC) |=> MEM_LATCH
		##1 1'b1 ##1 MEM_WR && MEM_WDATA == ($past(RD_DATA) ^ acc_q)
		&& acc_q == $past(acc_q, 3))
		else $error("xor of accumulator into direct byte wrong");
	a_parity_track: assert property (
		@(posedge CLK) disable iff (!RST_N)
		$changed(acc_q) |-> PARITY == ^acc_q)
		else $error("parity does not follow accumulator");
endmodule
`default_nettype wire

//--- hdl/xxe_pkg.sv
// Package of opcodes, address layout and states for the exchange/xor unit
`default_nettype none
package xxe_pkg;
	// Opcode patterns, prefix forms compared against the upper opcode bits
	localparam logic [4:0] OP_SWAP_REG_PFX = 5'h19; // 11001rrr
	localparam logic [6:0] OP_SWAP_IND_PFX = 7'h63; // 1100011i
	localparam logic [7:0] OP_SWAP_DIR     = 8'hc5; // 11000101
	localparam logic [6:0] OP_DIGIT_PFX    = 7'h6b; // 1101011i
	localparam logic [4:0] OP_XOR_REG_PFX  = 5'h0d; // 01101rrr
	localparam logic [6:0] OP_XOR_IND_PFX  = 7'h33; // 0110011i
	localparam logic [7:0] OP_XOR_DIR      = 8'h65; // 01100101
	localparam logic [7:0] OP_XOR_IMM      = 8'h64; // 01100100
	localparam logic [7:0] OP_XOR_DIR_ACC  = 8'h62; // 01100010
	localparam logic [7:0] OP_XOR_DIR_IMM  = 8'h63; // 01100011

	// Bank register address: {zero, bank, reg}; pointer regs use reg[2:1]=0
	localparam logic [2:0] BANK_ADDR_TOP   = 3'h0;
	localparam logic [1:0] PTR_REG_HIGH    = 2'h0;
	localparam logic [7:0] ACC_RESET       = 8'h00;
	localparam logic [7:0] BYTE_ZERO       = 8'h00;

	// Sequencer states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_PTR  = 3'b001,
		ST_PTRW = 3'b010,
		ST_OPRD = 3'b011,
		ST_CALC = 3'b100,
		ST_WR   = 3'b101
	} xxe_state_e;
endpackage
`default_nettype wire

//--- verification/exchange_and_xor_instruction_exec_bench.sv
// Self-checking bench for the exchange and exclusive-or unit
`timescale 1ns/1ns
`default_nettype none
module exchange_and_xor_instruction_exec_bench;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        start = 1'b0;
	logic        acc_wr_en = 1'b0;
	logic [1:0]  bank = 2'h0;
	logic [7:0]  opcode = 8'h00, op1 = 8'h00, op2 = 8'h00, acc_wr_data = 8'h00;
	logic        busy, done, illegal, mem_rd, mem_wr, mem_ind, mem_latch, parity;
	logic [7:0]  mem_addr, mem_wdata, acc, rd_data;
	logic [31:0] seed = 32'h05b10060;
	int          errors = 0, n_tests = 0, cycles = 0;
	logic [7:0]  base [10] = '{8'hc8, 8'hc6, 8'hc5, 8'hd6, 8'h68, 8'h66,
		8'h65, 8'h64, 8'h62, 8'h63};
	logic [7:0]  lowm [10] = '{8'h07, 8'h01, 8'h00, 8'h01, 8'h07, 8'h01,
		8'h00, 8'h00, 8'h00, 8'h00};
	xxe_exec dut (.CLK(clk), .RST_N(rst_n), .START(start), .OPCODE(opcode),
		.OPERAND1(op1), .OPERAND2(op2), .BANK(bank), .ACC_WR_EN(acc_wr_en),
		.ACC_WR_DATA(acc_wr_data), .RD_DATA(rd_data), .BUSY(busy),
		.DONE(done), .ILLEGAL(illegal), .MEM_RD(mem_rd), .MEM_WR(mem_wr),
		.MEM_IND(mem_ind), .MEM_LATCH(mem_latch), .MEM_ADDR(mem_addr),
		.MEM_WDATA(mem_wdata), .ACC(acc), .PARITY(parity));
	xxe_mem_model mdl (.CLK(clk), .MEM_RD(mem_rd), .MEM_WR(mem_wr),
		.MEM_IND(mem_ind), .MEM_LATCH(mem_latch), .MEM_ADDR(mem_addr),
		.MEM_WDATA(mem_wdata), .RD_DATA(rd_data));
	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h00000000);
	endfunction
	// Cycles from the taking edge to the done pulse
	function automatic logic [7:0] exp_lat(input logic [7:0] o);
		if (o == 8'h64) return 8'h01;
		if (o[7:1] == 7'h6b || o[7:1] == 7'h63) return 8'h06;
		if (o[7:1] == 7'h33) return 8'h05;
		if (o[7] || o == 8'h62 || o == 8'h63) return 8'h04;
		return 8'h03;
	endfunction
	// Eight shifts per draw so successive bytes are not merely shifted
	task automatic rnd(output logic [7:0] v);
		repeat (8) seed = lfsr(seed);
		v = seed[7:0];
	endtask
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic stop_test();
		$display("errors %0d comparisons %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// Called at a falling edge; the next request may go out in the done cycle
	task automatic issue(input logic [7:0] o, a, b, input logic [1:0] bk,
		output logic [7:0] lat);
		opcode = o;
		op1 = a;
		op2 = b;
		bank = bk;
		start = 1'b1;
		@(negedge clk);
		lat = 8'h01;
		// Left up when done is already here, so a request that follows
		// at once does not assign the strobe twice in one step
		if (done !== 1'b1) begin
			start = 1'b0;
			check({7'h0, busy}, 8'h01);
		end
		while (done !== 1'b1 && lat < 8'h0a) begin
			@(negedge clk);
			lat++;
		end
	endtask
	initial forever #20 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			errors++;
			stop_test();
		end
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		logic [7:0] r, op, a1, ptr, m, ea, wv, ae, lat;
		logic [8:0] x;
		logic [1:0] b;
		int         k;
		for (int i = 0; i < 512; i++) begin
			rnd(r);
			mdl.mem[i] = r;
		end
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		check(acc, 8'h00);
		// Load the accumulator as another core write would
		rnd(acc_wr_data);
		acc_wr_en = 1'b1;
		@(negedge clk);
		acc_wr_en = 1'b0;
		ae = acc_wr_data;
		check({7'h0, parity}, {7'h0, ^ae});
		// Unknown opcode: flag pulse, accumulator untouched
		opcode = 8'ha5;
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		check({7'h0, illegal}, 8'h01);
		check(acc, ae);
		$display("test refusal done");
		// Random forms, banks, addresses and data, back to back
		for (int t = 0; t < 100; t++) begin
			rnd(r);
			k = r % 10;
			rnd(r);
			op = base[k] | (r & lowm[k]);
			rnd(r);
			a1 = (k > 6) ? r : {1'b0, r[6:0]};
			rnd(r);
			b = r[1:0];
			rnd(r);
			ptr = mdl.mem[{4'h0, b, 2'h0, op[0]}];
			x = (k == 1 || k == 3 || k == 5) ? {ptr[7], ptr} :
				(k == 0 || k == 4) ? {4'h0, b, op[2:0]} : {1'b0, a1};
			m = mdl.mem[x];
			ea = ae;
			wv = m;
			case (k)
				0, 1, 2: begin
					ea = m;
					wv = ae;
				end
				3: begin
					ea = {ae[7:4], m[3:0]};
					wv = {m[7:4], ae[3:0]};
				end
				4, 5, 6: ea = ae ^ m;
				7: ea = ae ^ a1;
				8: wv = m ^ ae;
				default: wv = m ^ r;
			endcase
			issue(op, a1, r, b, lat);
			check(lat, exp_lat(op));
			check({7'h0, busy}, 8'h00);
			check(acc, ea);
			check({7'h0, parity}, {7'h0, ^ea});
			check(mdl.mem[x], wv);
			ae = ea;
			$display("test %0d opcode %h done", t, op);
		end
		stop_test();
	end
endmodule
`default_nettype wire

//--- verification/xxe_mem_model.sv
// Partner model: internal data memory and special function registers
`timescale 1ns/1ns
`default_nettype none
module xxe_mem_model (
	input  wire logic       CLK,
	input  wire logic       MEM_RD,
	input  wire logic       MEM_WR,
	input  wire logic       MEM_IND,
	input  wire logic       MEM_LATCH,
	input  wire logic [7:0] MEM_ADDR,
	input  wire logic [7:0] MEM_WDATA,
	output logic      [7:0] RD_DATA
);
	logic [7:0] mem [0:511];
	logic [8:0] idx;
	logic [7:0] pins;
	// Lower 128 bytes alias; upper indirect RAM sits apart from the SFRs
	assign idx = {MEM_IND & MEM_ADDR[7], MEM_ADDR};
	// Pins differ from the latch so a wrong read source shows up
	assign pins = (idx[7] && !idx[8] && !MEM_LATCH) ? ~mem[idx] : mem[idx];
	initial RD_DATA = 8'h00;
	////////////////////////////////////////////////////////////////////////
	// Registered read; data toggles outside reads instead of holding
	always @(posedge CLK) begin
		if (MEM_RD) begin
			RD_DATA <= pins;
		end else begin
			RD_DATA <= ~RD_DATA;
		end
		if (MEM_WR) begin
			mem[idx] <= MEM_WDATA;
		end
	end
endmodule
`default_nettype wire
